// file: lcm_byte_reg.sv
// one byte-lane register with byte-enable write
`timescale 1ns/1ps
module lcm_byte_reg #(
  parameter int               WIDTH       = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  // write port
  input  wire logic             i_we,
  input  wire logic [WIDTH-1:0] i_wdata,
  // stored value
  output logic      [WIDTH-1:0] o_q
);
  typedef struct packed {
    logic [WIDTH-1:0] q;
  } lcm_byte_s;

  lcm_byte_s state_r;
  lcm_byte_s state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (i_we) begin
      state_nxt.q = i_wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_r.q <= RESET_VALUE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_q = state_r.q;
endmodule : lcm_byte_reg

// file: lcm_host.sv
// host model issuing configuration cycles
`timescale 1ns/1ps
module lcm_host (
  // clock
  input  wire logic   i_clock,
  // configuration cycle
  output logic        o_wr,
  output logic        o_rd,
  output logic        o_mwr,
  output logic [7:0]  o_addr,
  output logic [3:0]  o_be,
  output logic [31:0] o_wdata
);
  initial begin
    {o_wr, o_rd, o_mwr, o_addr, o_be, o_wdata} = '0;
  end
  // one strobe cycle, data scrambled once released
  task automatic cyc(input logic w, m, input logic [7:0] a, input logic [3:0] b,
                     input logic [31:0] d);
    @(negedge i_clock);
    {o_wr, o_rd, o_mwr, o_addr, o_be, o_wdata} = {w, !w, m, a, b, d};
    @(negedge i_clock);
    {o_wr, o_rd, o_mwr, o_wdata} = {3'b000, ~d};
  endtask : cyc
endmodule : lcm_host

// file: lcm_pkg.sv
// shared constants for the loader configuration misc registers
package lcm_pkg;
  // configuration dword addresses (byte offsets)
  localparam logic [7:0]  MISC_CTRL_OFS   = 8'h50;
  localparam logic [7:0]  SUB_ALIAS_OFS   = 8'hF8;
  localparam logic [7:0]  SUB_MAKER_OFS   = 8'h2C;
  localparam logic [7:0]  CMD_STAT_OFS    = 8'h04;
  // field positions
  localparam int          REV_SEL_BIT     = 0;
  localparam int          INT_MASK_BIT    = 10;
  localparam int          INT_PEND_BIT    = 19;
  localparam int          SUB_IDENT_LSB   = 16;
  // reset values
  localparam logic [7:0]  MISC_CTRL_RST   = 8'h00;
  localparam logic [31:0] SUB_ALIAS_RST   = 32'h0000_0000;
endpackage : lcm_pkg

// file: lcm_regs.sv
// misc control and subsystem alias configuration registers
`timescale 1ns/1ps
module lcm_regs (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // configuration access, one dword per cycle
  input  wire logic        i_cfg_wr,
  input  wire logic        i_cfg_rd,
  input  wire logic [7:0]  i_cfg_addr,
  input  wire logic [3:0]  i_cfg_be,
  input  wire logic [31:0] i_cfg_wdata,
  output logic      [31:0] o_cfg_rdata,
  output logic             o_cfg_hit,
  // interrupt state from the function core
  input  wire logic        i_int_mask_wr,
  input  wire logic        i_int_raw,
  // derived status
  output logic             o_bus_revision_select,
  output logic             o_int_mask,
  output logic             o_int_pending,
  output logic             o_int_req,
  output logic      [15:0] o_sub_ident,
  output logic      [15:0] o_sub_maker_ident
);
  typedef struct packed {
    logic        rev_sel;
    logic        int_mask;
    logic [31:0] rdata;
    logic        hit;
  } lcm_regs_s;

  lcm_regs_s state_r;
  lcm_regs_s state_nxt;

  logic [31:0] alias_q;
  logic        hit_misc;
  logic        hit_alias;
  logic        hit_maker;
  logic        hit_cmd;
  logic [31:0] alias_view;
  logic [31:0] cmd_view;

  // address decode of the dwords answered here
  always_comb begin
    hit_misc  = 1'b0;
    hit_alias = 1'b0;
    hit_maker = 1'b0;
    hit_cmd   = 1'b0;
    case (i_cfg_addr)
      lcm_pkg::MISC_CTRL_OFS: begin
        hit_misc = 1'b1;
      end
      lcm_pkg::SUB_ALIAS_OFS: begin
        hit_alias = 1'b1;
      end
      lcm_pkg::SUB_MAKER_OFS: begin
        hit_maker = 1'b1;
      end
      lcm_pkg::CMD_STAT_OFS: begin
        hit_cmd = 1'b1;
      end
      default: begin
      end
    endcase
  end

  // four byte lanes shared by alias window and 2Ch/2Eh view
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      lcm_byte_reg #(
        .WIDTH       (8),
        .RESET_VALUE (lcm_pkg::SUB_ALIAS_RST[8*g +: 8])
      ) u_lane (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_we    (i_cfg_wr && hit_alias && i_cfg_be[g]),
        .i_wdata (i_cfg_wdata[8*g +: 8]),
        .o_q     (alias_q[8*g +: 8])
      );
    end
  endgenerate

  assign alias_view = alias_q;

  always_comb begin
    cmd_view = 32'h0000_0000;
    cmd_view[lcm_pkg::INT_MASK_BIT] = state_r.rev_sel & state_r.int_mask;
    cmd_view[lcm_pkg::INT_PEND_BIT] = state_r.rev_sel & i_int_raw;
  end

  always_comb begin
    state_nxt = state_r;
    state_nxt.hit = i_cfg_rd && (hit_misc || hit_alias || hit_maker || hit_cmd);
    state_nxt.rdata = 32'h0000_0000;
    if (i_cfg_wr && hit_misc && i_cfg_be[0]) begin
      state_nxt.rev_sel = i_cfg_wdata[lcm_pkg::REV_SEL_BIT];
    end
    if (!state_r.rev_sel) begin
      state_nxt.int_mask = 1'b0;
    end else if (i_int_mask_wr) begin
      state_nxt.int_mask = i_cfg_wdata[lcm_pkg::INT_MASK_BIT];
    end
    // read mux, unmapped dwords answer nothing
    if (i_cfg_rd) begin
      case (i_cfg_addr)
        lcm_pkg::MISC_CTRL_OFS: begin
          state_nxt.rdata = {31'h0000_0000, state_r.rev_sel};
        end
        lcm_pkg::SUB_ALIAS_OFS, lcm_pkg::SUB_MAKER_OFS: begin
          state_nxt.rdata = alias_view;
        end
        lcm_pkg::CMD_STAT_OFS: begin
          state_nxt.rdata = cmd_view;
        end
        default: begin
          state_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_cfg_rdata           = state_r.rdata;
  assign o_cfg_hit             = state_r.hit;
  assign o_bus_revision_select = state_r.rev_sel;
  assign o_int_mask            = state_r.rev_sel & state_r.int_mask;
  assign o_int_pending         = state_r.rev_sel & i_int_raw;
  assign o_int_req             = i_int_raw & ~(state_r.rev_sel & state_r.int_mask);
  assign o_sub_ident           = alias_q[31:lcm_pkg::SUB_IDENT_LSB];
  assign o_sub_maker_ident     = alias_q[lcm_pkg::SUB_IDENT_LSB-1:0];

  // register behaviour checks
  a_misc_upper_zero: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $past(i_cfg_rd) && $past(hit_misc) |-> o_cfg_rdata[31:1] == 31'h0)
    else $error("misc control upper bits not zero");

  a_misc_read_bit: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $past(i_cfg_rd) && $past(hit_misc) |-> o_cfg_rdata[0] == $past(o_bus_revision_select))
    else $error("misc control bit 0 reads wrong");

  a_read_quiet: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !$past(i_cfg_rd) |-> !o_cfg_hit && o_cfg_rdata == 32'h0000_0000)
    else $error("read answer outside its cycle");

  a_mask_needs_rev: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !o_bus_revision_select |-> !o_int_mask && !o_int_pending)
    else $error("2.3 bits active in 2.2 mode");

  a_mask_cleared_22: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !state_r.rev_sel |=> !state_r.int_mask)
    else $error("mask kept in 2.2 mode");

  a_no_suppress_22: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !o_bus_revision_select |-> o_int_req == i_int_raw)
    else $error("interrupt suppressed in 2.2 mode");

  a_pend_in_23: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_bus_revision_select |-> o_int_pending == i_int_raw)
    else $error("pending bit not functional in 2.3 mode");

  a_mask_write_23: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    state_r.rev_sel && i_int_mask_wr
    |=> state_r.int_mask == $past(i_cfg_wdata[lcm_pkg::INT_MASK_BIT]))
    else $error("mask write lost in 2.3 mode");

  a_req_masked_23: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_bus_revision_select && o_int_mask |-> !o_int_req)
    else $error("masked interrupt still requested");

  a_cmd_read: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $past(i_cfg_rd) && $past(hit_cmd)
    |-> o_cfg_rdata[lcm_pkg::INT_MASK_BIT] == $past(o_int_mask)
        && o_cfg_rdata[lcm_pkg::INT_PEND_BIT] == $past(o_int_pending))
    else $error("command status view wrong");

  a_rev_after_rst: assert property (@(posedge i_clock)
    !$past(i_rst_n) |-> !o_bus_revision_select)
    else $error("revision select not clear after reset");

  a_rev_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_cfg_wr && hit_misc && i_cfg_be[0]
    |=> o_bus_revision_select == $past(i_cfg_wdata[0]))
    else $error("revision select write lost");

  a_rev_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !(i_cfg_wr && hit_misc && i_cfg_be[0])
    |=> $stable(o_bus_revision_select))
    else $error("revision select changed without write");

  a_ident_alias: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $past(i_cfg_wr) && $past(hit_alias) && $past(i_cfg_be) == 4'hF
    |-> o_sub_ident == $past(i_cfg_wdata[31:16]))
    else $error("sub ident not updated");

  a_ident_keep_hi: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_cfg_wr && hit_alias && !i_cfg_be[3]
    |=> $stable(o_sub_ident[15:8]))
    else $error("disabled sub ident lane changed");

  a_maker_alias: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $past(i_cfg_wr) && $past(hit_alias) && $past(i_cfg_be) == 4'hF
    |-> o_sub_maker_ident == $past(i_cfg_wdata[15:0]))
    else $error("sub maker ident not updated");

  a_maker_keep_lo: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_cfg_wr && hit_alias && !i_cfg_be[0]
    |=> $stable(o_sub_maker_ident[7:0]))
    else $error("disabled sub maker ident lane changed");

  a_alias_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !(i_cfg_wr && hit_alias)
    |=> $stable(o_sub_ident) && $stable(o_sub_maker_ident))
    else $error("subsystem alias changed without write");

  a_alias_read: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $past(i_cfg_rd) && ($past(hit_alias) || $past(hit_maker))
    |-> o_cfg_rdata == {$past(o_sub_ident), $past(o_sub_maker_ident)})
    else $error("subsystem alias read wrong");
endmodule : lcm_regs

// file: lcm_regs_test.sv
// self-checking bench for the misc configuration registers
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module lcm_regs_test;
  logic        i_clock = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        raw     = 1'b0;
  logic        wr, rd, mwr, hit, rev, mask, pend, req;
  logic [7:0]  addr;
  logic [3:0]  be, b;
  logic [31:0] wdata, rdata, v, cur, e;
  logic [15:0] sid, smid;
  logic [31:0] exp_q[$];
  int          bad_count = 0;
  int          check_count = 0;
  always #5 i_clock = ~i_clock;
  lcm_host host (.i_clock(i_clock), .o_wr(wr), .o_rd(rd), .o_mwr(mwr), .o_addr(addr),
                 .o_be(be), .o_wdata(wdata));
  lcm_regs dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_cfg_wr(wr), .i_cfg_rd(rd),
    .i_cfg_addr(addr), .i_cfg_be(be), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata),
    .o_cfg_hit(hit), .i_int_mask_wr(mwr), .i_int_raw(raw), .o_bus_revision_select(rev),
    .o_int_mask(mask), .o_int_pending(pend), .o_int_req(req), .o_sub_ident(sid),
    .o_sub_maker_ident(smid));
  task automatic finish_test;
    if (exp_q.size() != 0) bad_count++;
    if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  task automatic rd_exp(input logic [7:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    host.cyc(1'b0, 1'b0, a, 4'h0, 32'h0);
  endtask : rd_exp
  // scoreboard: every hit consumes the oldest expected read
  always @(negedge i_clock) if (hit === 1'b1) begin
    if (exp_q.size() == 0) `CHK("stray hit", 1'b0, hit)
    else begin
      e = exp_q.pop_front();
      `CHK("rdata", e, rdata)
    end
  end
  initial begin
    #60000;
    bad_count++;
    finish_test();
  end
  initial begin
    void'($urandom(32'hC541A742));
    repeat (16) @(posedge i_clock);
    @(negedge i_clock) i_rst_n = 1'b1;
    `CHK("rev", 1'b0, rev)
    rd_exp(lcm_pkg::MISC_CTRL_OFS, 32'h0);
    rd_exp(lcm_pkg::SUB_ALIAS_OFS, 32'h0);
    cur = 32'h0;
    for (int k = 0; k < 6; k++) begin
      v = $urandom();
      b = (k == 0) ? 4'hF : 4'($urandom());
      for (int i = 0; i < 4; i++) if (b[i]) cur[8*i+:8] = v[8*i+:8];
      host.cyc(1'b1, 1'b0, lcm_pkg::SUB_ALIAS_OFS, b, v);
      host.cyc(1'b1, 1'b0, lcm_pkg::SUB_MAKER_OFS, 4'hF, ~v);
      host.cyc(1'b1, 1'b0, 8'h60, 4'hF, v);
      `CHK("sub_ident", cur[31:16], sid)
      `CHK("sub_maker_ident", cur[15:0], smid)
      rd_exp(lcm_pkg::SUB_ALIAS_OFS, cur);
      rd_exp(lcm_pkg::SUB_MAKER_OFS, cur);
      host.cyc(1'b0, 1'b0, 8'h60, 4'h0, 32'h0);
    end
    raw = 1'b1;
    for (int m = 1; m >= 0; m--) begin
      host.cyc(1'b1, 1'b0, lcm_pkg::MISC_CTRL_OFS, 4'hF, {31'h7FFFFFFF, m[0]});
      rd_exp(lcm_pkg::MISC_CTRL_OFS, {31'h0, m[0]});
      host.cyc(1'b1, 1'b1, lcm_pkg::CMD_STAT_OFS, 4'hF, 32'h400);
      `CHK("rev", m[0], rev)
      `CHK("mask", m[0], mask)
      `CHK("pending", m[0], pend)
      `CHK("req", !m[0], req)
      rd_exp(lcm_pkg::CMD_STAT_OFS, {12'h0, m[0], 8'h0, m[0], 10'h0});
    end
    host.cyc(1'b1, 1'b0, lcm_pkg::MISC_CTRL_OFS, 4'h1, 32'h0000_0001);
    `CHK("rev", 1'b1, rev)
    `CHK("mask", 1'b0, mask)
    `CHK("req", 1'b1, req)
    raw = 1'b0;
    @(negedge i_clock);
    `CHK("pending", 1'b0, pend)
    `CHK("req", 1'b0, req)
    @(negedge i_clock) i_rst_n = 1'b0;
    repeat (2) @(negedge i_clock);
    i_rst_n = 1'b1;
    `CHK("rev", 1'b0, rev)
    rd_exp(lcm_pkg::SUB_ALIAS_OFS, 32'h0);
    rd_exp(lcm_pkg::MISC_CTRL_OFS, 32'h0);
    repeat (3) @(negedge i_clock);
    finish_test();
  end
endmodule : lcm_regs_test
